// [include/fan_seq_pkg.sv]
// shared constants and types of the fan speed sequencer
package fan_seq_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;
  localparam int HALF_BYTES = 2;
  localparam int STD_W = 4;
  localparam int SP_W = 10;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_RUNUP = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_PREIGN = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_SPEED_REF = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_ABS_SPEED = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_RAMP_UP = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_RAMP_DN = 5'h1C;

  // control register fields
  localparam int CTRL_STD_EN = 0;
  localparam int CTRL_DRV_EN = 1;
  localparam int CTRL_IO_SEL = 2;
  localparam int CTRL_GAS = 3;
  localparam int CTRL_START = 4;
  localparam int CTRL_MRESET = 5;

  // status register fields
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_NEED_RST = 8;
  localparam int STAT_IGN_FAULT = 9;
  localparam int STAT_DRV_APPLIED = 10;
  localparam int STAT_IO_APPLIED = 11;
  localparam int STAT_ERR_LSB = 16;

  // standardization status codes
  localparam logic [STD_W-1:0] STD_IDLE = 4'h0;
  localparam logic [STD_W-1:0] STD_POSITION = 4'h1;
  localparam logic [STD_W-1:0] STD_MEASURE = 4'h2;
  localparam logic [STD_W-1:0] STD_DONE = 4'h4;
  localparam logic [STD_W-1:0] STD_REFUSED = 4'h5;
  localparam logic [STD_W-1:0] STD_ABORTED = 4'h6;

  // error codes
  localparam logic [HALF_W-1:0] ERR_NONE = 16'h0000;
  localparam logic [HALF_W-1:0] ERR_NOT_STANDBY = 16'h0C4E;
  localparam logic [HALF_W-1:0] ERR_FLANGE_OPEN = 16'h0C50;
  localparam logic [HALF_W-1:0] ERR_DRIVE_OFF = 16'h0C52;
  localparam logic [HALF_W-1:0] ERR_IGN_RELAY = 16'h13CE;

  // sequence phases
  localparam logic [7:0] PH_STANDBY = 8'h0C;
  localparam logic [7:0] PH_FAN_ON = 8'h14;
  localparam logic [7:0] PH_PREIGN = 8'h26;
  localparam logic [7:0] PH_SAFETY1 = 8'h28;
  localparam logic [7:0] PH_LIGHT_ON = 8'h36;
  localparam logic [7:0] PH_LIGHT_OFF = 8'h3E;

  // setpoint scale: full scale and the 95 percent used while standardizing
  localparam int SP_FULL_I = 1000;
  localparam int STD_PERCENT = 95;
  localparam logic [SP_W-1:0] SP_ZERO = 10'h000;
  localparam logic [SP_W-1:0] SP_STD = SP_W'(SP_FULL_I * STD_PERCENT / 100);

  // millisecond counts, speed tolerance and ramp down shift
  localparam logic [HALF_W-1:0] MS_ZERO = 16'h0000;
  localparam logic [HALF_W-1:0] MS_ONE = 16'h0001;
  localparam logic [HALF_W-1:0] MS_MAX = 16'hFFFF;
  localparam logic [HALF_W-1:0] RST_RUNUP_MS = 16'h0BB8;
  localparam logic [HALF_W-1:0] RST_PREIGN_MS = 16'h07D0;
  localparam logic [HALF_W-1:0] STABLE_HOLD_MS = 16'h01F4;
  localparam logic [HALF_W-1:0] STD_TIMEOUT_MS = 16'hEA60;
  localparam logic [HALF_W-1:0] RELAY_SETTLE_MS = 16'h0014;
  localparam logic [HALF_W-1:0] SPEED_TOL = 16'h0005;
  localparam int RAMP_DN_SHIFT = 3;
endpackage

// [src/tick_div.sv]
// divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ns
module tick_div #(
  parameter int unsigned DIV = 100000
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  output logic tick_out
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t s;
  div_state_t n;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (s.cnt == LAST) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick_out = s.tick;
endmodule

// [src/fan_seq.sv]
// fan speed standardization sequencer and phase-driven burner outputs
// Function
// - standardize only while enable setting is on; checked only at start, clearing it during a run does not abort
// - start needs safety loop and flange closed
// - refuse outside standby, report 3150
// - refuse with flange open, report 3152
// - refuse with speed drive off, report 3154
// - first move all actuators to prepurge
// - then drive setpoint at 95 percent
// - store stable speed as 100 percent reference
// - readable standardization status value
// - compute ramp up and down times automatically
// - drive enable and IO select changes apply only after manual reset; gas and enable settings apply at once
// - fan contactor on in phase 20
// - wait fan run-up time before prepurge
// - no air pressure at prepurge: shutdown
// - light on phase 54, off phase 62
// - gas: ignition on in phases 38 and 40, preignition done after preignition time
// - ignition readback mismatch reports 5070
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module fan_seq
  import fan_seq_pkg::*;
#(
  parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [DATA_W-1:0] avs_writedata_in,
  input wire logic [BE_W-1:0] avs_byteenable_in,
  output logic [DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [7:0] phase_in,
  input wire logic safety_loop_in,
  input wire logic flange_closed_in,
  input wire logic air_pressure_in,
  input wire logic at_prepurge_in,
  input wire logic [HALF_W-1:0] speed_in,
  input wire logic ign_readback_in,
  output logic fan_on_out,
  output logic speed_drive_run_out,
  output logic [SP_W-1:0] speed_setpoint_out,
  output logic prepurge_cmd_out,
  output logic light_on_out,
  output logic ignition_out,
  output logic preign_done_out,
  output logic shutdown_out
);
  typedef enum logic [1:0] {S_IDLE, S_POSITION, S_MEASURE} std_state_t;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
    logic std_en;
    logic gas;
    logic ctrl_drv;
    logic ctrl_io;
    logic app_drv;
    logic app_io;
    logic [HALF_W-1:0] runup_ms;
    logic [HALF_W-1:0] preign_ms;
    logic [HALF_W-1:0] speed_ref;
    logic [HALF_W-1:0] abs_speed;
    logic [HALF_W-1:0] ramp_up;
    logic [HALF_W-1:0] ramp_dn;
    logic [HALF_W-1:0] err_code;
    logic [STD_W-1:0] std_status;
    std_state_t std_state;
    logic [SP_W-1:0] setpoint;
    logic [HALF_W-1:0] tup_cnt;
    logic [HALF_W-1:0] stable_cnt;
    logic [HALF_W-1:0] last_speed;
    logic fan_on;
    logic drive_run;
    logic [HALF_W-1:0] runup_cnt;
    logic seq_prepurge;
    logic prepurge;
    logic air_checked;
    logic shutdown;
    logic light_on;
    logic ign_on;
    logic [HALF_W-1:0] ign_cnt;
    logic preign_sent;
    logic preign_done;
    logic ign_fault;
    logic [HALF_W-1:0] mis_cnt;
  } state_t;

  state_t s;
  state_t n;
  logic [1:0] rst_pipe_q;
  logic rst_sync_b;
  logic tick;
  logic start;
  logic mreset;
  logic need_reset;
  logic drive_ok;
  logic in_ign;
  logic [HALF_W:0] rsum;

  function automatic logic [HALF_W-1:0] merge_half(
    input logic [HALF_W-1:0] old,
    input logic [HALF_W-1:0] nw,
    input logic [HALF_BYTES-1:0] be
  );
    logic [HALF_W-1:0] r;
    r = old;
    for (int i = 0; i < HALF_BYTES; i++) begin
      if (be[i]) begin
        r[i*BYTE_W +: BYTE_W] = nw[i*BYTE_W +: BYTE_W];
      end
    end
    return r;
  endfunction

  function automatic logic near(
    input logic [HALF_W-1:0] a,
    input logic [HALF_W-1:0] b
  );
    logic [HALF_W-1:0] d;
    d = (a > b) ? a - b : b - a;
    return d <= SPEED_TOL;
  endfunction

  function automatic logic [DATA_W-1:0] reg_read(
    input state_t st,
    input logic [ADDR_W-1:0] a,
    input logic nr
  );
    logic [DATA_W-1:0] r;
    r = '0;
    case (a)
      OFS_CTRL: begin
        r[CTRL_STD_EN] = st.std_en;
        r[CTRL_DRV_EN] = st.ctrl_drv;
        r[CTRL_IO_SEL] = st.ctrl_io;
        r[CTRL_GAS] = st.gas;
      end
      OFS_STATUS: begin
        r[STAT_CODE_LSB +: STD_W] = st.std_status;
        r[STAT_NEED_RST] = nr;
        r[STAT_IGN_FAULT] = st.ign_fault;
        r[STAT_DRV_APPLIED] = st.app_drv;
        r[STAT_IO_APPLIED] = st.app_io;
        r[STAT_ERR_LSB +: HALF_W] = st.err_code;
      end
      OFS_RUNUP: r[HALF_W-1:0] = st.runup_ms;
      OFS_PREIGN: r[HALF_W-1:0] = st.preign_ms;
      OFS_SPEED_REF: r[HALF_W-1:0] = st.speed_ref;
      OFS_ABS_SPEED: r[HALF_W-1:0] = st.abs_speed;
      OFS_RAMP_UP: r[HALF_W-1:0] = st.ramp_up;
      OFS_RAMP_DN: r[HALF_W-1:0] = st.ramp_dn;
      default: r = '0;
    endcase
    return r;
  endfunction

  // reset release through two flops
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe_q[1];

  tick_div #(
    .DIV(CYC_PER_MS_P)
  ) u_ms_tick (
    .clk_in(core_clk_in),
    .rst_b_in(rst_sync_b),
    .tick_out(tick)
  );

  assign need_reset = (s.ctrl_drv != s.app_drv) || (s.ctrl_io != s.app_io);

  always_comb begin
    n = s;
    start = 1'b0;
    mreset = 1'b0;
    rsum = '0;
    n.ack = 1'b0;
    n.shutdown = 1'b0;
    n.preign_done = 1'b0;

    // bus slave: one wait state, write lands when waitrequest drops
    if ((avs_read_in || avs_write_in) && !s.ack) begin
      n.ack = 1'b1;
      if (avs_read_in) begin
        n.rdata = reg_read(s, avs_address_in, need_reset);
      end
    end
    if (avs_write_in && s.ack) begin
      case (avs_address_in)
        OFS_CTRL: begin
          if (avs_byteenable_in[0]) begin
            n.std_en = avs_writedata_in[CTRL_STD_EN];
            n.ctrl_drv = avs_writedata_in[CTRL_DRV_EN];
            n.ctrl_io = avs_writedata_in[CTRL_IO_SEL];
            n.gas = avs_writedata_in[CTRL_GAS];
            start = avs_writedata_in[CTRL_START];
            mreset = avs_writedata_in[CTRL_MRESET];
          end
        end
        OFS_RUNUP: n.runup_ms = merge_half(s.runup_ms,
          avs_writedata_in[HALF_W-1:0], avs_byteenable_in[HALF_BYTES-1:0]);
        OFS_PREIGN: n.preign_ms = merge_half(s.preign_ms,
          avs_writedata_in[HALF_W-1:0], avs_byteenable_in[HALF_BYTES-1:0]);
        OFS_RAMP_UP: n.ramp_up = merge_half(s.ramp_up,
          avs_writedata_in[HALF_W-1:0], avs_byteenable_in[HALF_BYTES-1:0]);
        OFS_RAMP_DN: n.ramp_dn = merge_half(s.ramp_dn,
          avs_writedata_in[HALF_W-1:0], avs_byteenable_in[HALF_BYTES-1:0]);
        default: ;
      endcase
    end

    // manual reset takes over new config and clears faults
    if (mreset) begin
      n.app_drv = n.ctrl_drv;
      n.app_io = n.ctrl_io;
      n.err_code = ERR_NONE;
      n.ign_fault = 1'b0;
    end

    n.abs_speed = speed_in;
    drive_ok = s.app_drv && s.app_io;

    // standardization sequence
    case (s.std_state)
      S_IDLE: begin
        n.setpoint = SP_ZERO;
        if (start && n.std_en) begin
          if (phase_in != PH_STANDBY) begin
            n.std_status = STD_REFUSED;
            n.err_code = ERR_NOT_STANDBY;
          end else if (!flange_closed_in) begin
            n.std_status = STD_REFUSED;
            n.err_code = ERR_FLANGE_OPEN;
          end else if (!drive_ok) begin
            n.std_status = STD_REFUSED;
            n.err_code = ERR_DRIVE_OFF;
          end else if (!safety_loop_in) begin
            n.std_status = STD_REFUSED;
          end else begin
            n.std_state = S_POSITION;
            n.std_status = STD_POSITION;
          end
        end
      end
      S_POSITION: begin
        if (at_prepurge_in) begin
          n.std_state = S_MEASURE;
          n.std_status = STD_MEASURE;
          n.setpoint = SP_STD;
          n.tup_cnt = MS_ZERO;
          n.stable_cnt = MS_ZERO;
          n.last_speed = speed_in;
        end
      end
      S_MEASURE: begin
        if (tick) begin
          n.last_speed = speed_in;
          if (s.tup_cnt != MS_MAX) begin
            n.tup_cnt = s.tup_cnt + MS_ONE;
          end
          if (near(speed_in, s.last_speed)) begin
            n.stable_cnt = s.stable_cnt + MS_ONE;
          end else begin
            n.stable_cnt = MS_ZERO;
          end
          if (s.stable_cnt == STABLE_HOLD_MS) begin
            n.speed_ref = speed_in;
            rsum = {1'b0, s.tup_cnt} + {1'b0, s.tup_cnt >> RAMP_DN_SHIFT};
            n.ramp_up = s.tup_cnt;
            n.ramp_dn = rsum[HALF_W] ? MS_MAX : rsum[HALF_W-1:0];
            n.std_status = STD_DONE;
            n.setpoint = SP_ZERO;
            n.std_state = S_IDLE;
          end else if (s.tup_cnt >= STD_TIMEOUT_MS) begin
            n.std_status = STD_ABORTED;
            n.setpoint = SP_ZERO;
            n.std_state = S_IDLE;
          end
        end
      end
      default: n.std_state = S_IDLE;
    endcase
    // loss of safety loop, flange closed or standby phase while running aborts
    if (s.std_state != S_IDLE && (!safety_loop_in || !flange_closed_in
        || phase_in != PH_STANDBY)) begin
      n.std_status = STD_ABORTED;
      n.setpoint = SP_ZERO;
      n.std_state = S_IDLE;
    end

    // fan contactor, run-up and air pressure check
    n.fan_on = (phase_in >= PH_FAN_ON) || (n.std_state == S_MEASURE);
    n.drive_run = n.fan_on && n.app_drv;
    if (!s.fan_on || phase_in < PH_FAN_ON) begin
      n.runup_cnt = MS_ZERO;
      n.seq_prepurge = 1'b0;
      n.air_checked = 1'b0;
    end else if (!s.seq_prepurge && tick) begin
      if (s.runup_cnt >= s.runup_ms) begin
        n.seq_prepurge = 1'b1;
      end else begin
        n.runup_cnt = s.runup_cnt + MS_ONE;
      end
    end
    if (s.seq_prepurge && at_prepurge_in && !s.air_checked) begin
      n.air_checked = 1'b1;
      if (!air_pressure_in) begin
        n.shutdown = 1'b1;
      end
    end
    n.prepurge = n.seq_prepurge || (n.std_state != S_IDLE);

    // operating light
    if (phase_in == PH_LIGHT_ON) begin
      n.light_on = 1'b1;
    end else if (phase_in == PH_LIGHT_OFF || phase_in < PH_FAN_ON) begin
      n.light_on = 1'b0;
    end

    // ignition with preignition timing
    in_ign = s.gas && (phase_in == PH_PREIGN || phase_in == PH_SAFETY1);
    if (!in_ign) begin
      n.ign_cnt = MS_ZERO;
      n.preign_sent = 1'b0;
    end else if (phase_in == PH_PREIGN && tick) begin
      if (s.ign_cnt < s.preign_ms) begin
        n.ign_cnt = s.ign_cnt + MS_ONE;
      end else if (!s.preign_sent) begin
        n.preign_sent = 1'b1;
        n.preign_done = 1'b1;
      end
    end

    // ignition relay readback supervision
    if (s.ign_on != ign_readback_in) begin
      if (tick && s.mis_cnt != MS_MAX) begin
        n.mis_cnt = s.mis_cnt + MS_ONE;
      end
      if (s.mis_cnt >= RELAY_SETTLE_MS && !s.ign_fault) begin
        n.ign_fault = 1'b1;
        n.err_code = ERR_IGN_RELAY;
        n.shutdown = 1'b1;
      end
    end else begin
      n.mis_cnt = MS_ZERO;
    end
    n.ign_on = in_ign && !n.ign_fault;
  end

  always_ff @(posedge core_clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s <= '0;
      s.runup_ms <= RST_RUNUP_MS;
      s.preign_ms <= RST_PREIGN_MS;
    end else begin
      s <= n;
    end
  end

  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !s.ack;
  assign avs_readdata_out = s.rdata;
  assign fan_on_out = s.fan_on;
  assign speed_drive_run_out = s.drive_run;
  assign speed_setpoint_out = s.setpoint;
  assign prepurge_cmd_out = s.prepurge;
  assign light_on_out = s.light_on;
  assign ignition_out = s.ign_on;
  assign preign_done_out = s.preign_done;
  assign shutdown_out = s.shutdown;
endmodule

// [bench/fan_seq_asserts.sv]
// concurrent checks on the fan sequencer ports
`timescale 1ns/1ns
module fan_seq_asserts
  import fan_seq_pkg::*;
#(
  parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic [7:0] phase_in,
  input wire logic at_prepurge_in,
  input wire logic fan_on_out,
  input wire logic [SP_W-1:0] speed_setpoint_out,
  input wire logic light_on_out,
  input wire logic ignition_out,
  input wire logic preign_done_out,
  input wire logic shutdown_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_ign_phase;
    $past(phase_in) == PH_PREIGN || $past(phase_in) == PH_SAFETY1;
  endsequence
  sequence s_positioned;
    $past(at_prepurge_in);
  endsequence

  a_fan_phase: assert property (
    phase_in >= PH_FAN_ON |=> fan_on_out)
    else $error("fan contactor not on in fan phase");
  a_light_on: assert property (
    phase_in == PH_LIGHT_ON |=> light_on_out)
    else $error("light not on in light phase");
  a_light_off: assert property (
    phase_in == PH_LIGHT_OFF |=> !light_on_out)
    else $error("light not off in shutdown phase");
  a_sp_limit: assert property (
    speed_setpoint_out <= SP_STD)
    else $error("setpoint above standardization level");
  a_sp_after_pos: assert property (
    $rose(speed_setpoint_out == SP_STD) |-> s_positioned)
    else $error("setpoint raised before prepurge reached");
  a_ign_phase: assert property (
    ignition_out |-> s_ign_phase)
    else $error("ignition on outside ignition phases");
  a_preign_pulse: assert property (
    preign_done_out |=> !preign_done_out)
    else $error("preignition done longer than one cycle");
  a_shut_pulse: assert property (
    shutdown_out |=> !shutdown_out)
    else $error("shutdown request longer than one cycle");
  a_one_wait: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out)
    else $error("bus answer not after one wait state");
endmodule

// [bench/fan_drive_model.sv]
// speed drive, fan, actuators and ignition relay on the far side
`timescale 1ns/1ns
module fan_drive_model
  import fan_seq_pkg::*;
(
  input wire logic clk_in,
  input wire logic fan_on_in,
  input wire logic run_in,
  input wire logic [SP_W-1:0] sp_in,
  input wire logic prepurge_in,
  input wire logic ign_in,
  input wire logic air_ok_in,
  input wire logic ign_bad_in,
  output logic [HALF_W-1:0] speed_out,
  output logic at_prepurge_out,
  output logic air_out,
  output logic ign_rb_out
);
  logic [HALF_W-1:0] tgt;
  logic [3:0] pos_cnt;
  // full scale of 1000 maps to 2000 speed units at maximum frequency
  assign tgt = run_in ? {5'h00, sp_in, 1'b0} : 16'h0000;
  assign air_out = fan_on_in & air_ok_in;
  assign ign_rb_out = ign_in ^ ign_bad_in;
  initial begin
    speed_out = 16'h0000;
    pos_cnt = 4'h0;
  end
  // motor follows ramp one unit per cycle, down to standstill
  always @(posedge clk_in) begin
    if (speed_out < tgt) speed_out <= speed_out + 16'h0001;
    else if (speed_out > tgt) speed_out <= speed_out - 16'h0001;
  end
  // actuators need eight cycles to reach prepurge
  always @(posedge clk_in) begin
    if (!prepurge_in) pos_cnt <= 4'h0;
    else if (pos_cnt != 4'h8) pos_cnt <= pos_cnt + 4'h1;
  end
  assign at_prepurge_out = (pos_cnt == 4'h8);
endmodule

// [bench/tb_fan_seq.sv]
// self-checking bench of the fan speed sequencer
`timescale 1ns/1ns
module tb_fan_seq
  import fan_seq_pkg::*;
;
  logic clk = 0, rst_b = 0, rd = 0, wr = 0, wreq, loop = 1, flg = 1;
  logic air_ok = 1, ign_bad = 0, atp, air, igrb, fan, run, pre, lit;
  logic ign, pdn, shd;
  logic [ADDR_W-1:0] adr = 5'h00;
  logic [DATA_W-1:0] wd = 32'h0, rdd, q;
  logic [7:0] ph = 8'h00;
  logic [HALF_W-1:0] spd;
  logic [SP_W-1:0] sp;
  int err_count = 0, checks = 0, cyc = 0, n, k;

  always #5 clk = ~clk;

  fan_seq #(.CYC_PER_MS_P(10)) i_dut (.core_clk_in(clk),
    .rst_b_in(rst_b), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdd),
    .avs_waitrequest_out(wreq), .phase_in(ph), .safety_loop_in(loop),
    .flange_closed_in(flg), .air_pressure_in(air),
    .at_prepurge_in(atp), .speed_in(spd), .ign_readback_in(igrb),
    .fan_on_out(fan), .speed_drive_run_out(run),
    .speed_setpoint_out(sp), .prepurge_cmd_out(pre),
    .light_on_out(lit), .ignition_out(ign), .preign_done_out(pdn),
    .shutdown_out(shd));

  fan_drive_model i_far (.clk_in(clk), .fan_on_in(fan), .run_in(run),
    .sp_in(sp), .prepurge_in(pre), .ign_in(ign), .air_ok_in(air_ok),
    .ign_bad_in(ign_bad), .speed_out(spd), .at_prepurge_out(atp),
    .air_out(air), .ign_rb_out(igrb));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("errors=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one bus cycle, held until waitrequest is seen low
  task bus(input logic w, input logic [ADDR_W-1:0] a,
           input logic [DATA_W-1:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdd;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task st;
    bus(1'b0, OFS_STATUS, 32'h0);
  endtask

  task setp(input logic [7:0] p);
    @(posedge clk);
    ph <= p;
  endtask

  task go(input int c);
    repeat (c) @(negedge clk);
  endtask

  task t_refuse;
    bus(1'b1, OFS_CTRL, 32'h11);
    st;
    chk(q[31:16], ERR_NOT_STANDBY);
    chk(q[3:0], STD_REFUSED);
    @(posedge clk);
    ph <= PH_STANDBY;
    flg <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h11);
    st;
    chk(q[31:16], ERR_FLANGE_OPEN);
    @(posedge clk);
    flg <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h11);
    st;
    chk(q[31:16], ERR_DRIVE_OFF);
  endtask

  task t_config;
    bus(1'b1, OFS_CTRL, 32'h07);
    st;
    chk(q[STAT_NEED_RST], 1'b1);
    chk(q[STAT_DRV_APPLIED], 1'b0);
    bus(1'b1, OFS_CTRL, 32'h27);
    st;
    chk(q[11:8], 4'hC);
    chk(q[31:16], ERR_NONE);
  endtask

  task t_gate;
    bus(1'b1, OFS_CTRL, 32'h16);
    st;
    chk(q[3:0] == STD_POSITION, 1'b0);
    go(20);
    chk(pre, 1'b0);
    @(posedge clk);
    loop <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h17);
    st;
    chk(q[3:0], STD_REFUSED);
    chk(q[31:16], ERR_NONE);
    go(20);
    chk(pre, 1'b0);
    @(posedge clk);
    loop <= 1'b1;
  endtask

  task t_std;
    logic [31:0] up;
    bus(1'b1, OFS_CTRL, 32'h17);
    go(1);
    chk(pre, 1'b1);
    chk(sp, SP_ZERO);
    for (n = 0; n < 200; n++) begin
      st;
      if (q[3:0] == STD_MEASURE) break;
    end
    chk(sp, SP_STD);
    for (n = 0; n < 4000; n++) begin
      st;
      if (q[3:0] == STD_DONE) break;
    end
    chk(q[3:0], STD_DONE);
    chk(sp, SP_ZERO);
    bus(1'b0, OFS_SPEED_REF, 32'h0);
    chk(q, 32'(SP_STD) * 2);
    bus(1'b0, OFS_RAMP_UP, 32'h0);
    up = q;
    chk(up != 32'h0, 1'b1);
    bus(1'b0, OFS_RAMP_DN, 32'h0);
    chk(q, up + (up >> RAMP_DN_SHIFT));
    go(2100);
    bus(1'b0, OFS_ABS_SPEED, 32'h0);
    chk(q, 32'h0);
  endtask

  task t_fan;
    bus(1'b1, OFS_RUNUP, 32'h5);
    bus(1'b1, OFS_PREIGN, 32'h3);
    @(posedge clk);
    air_ok <= 1'b0;
    ph <= PH_FAN_ON;
    go(2);
    chk(fan, 1'b1);
    chk(run, 1'b1);
    for (k = 0; k < 200 && pre !== 1'b1; k++) go(1);
    chk(k >= 40 && k <= 70, 1'b1);
    for (k = 0; k < 30 && shd !== 1'b1; k++) go(1);
    chk(shd, 1'b1);
    setp(PH_LIGHT_ON);
    go(2);
    chk(lit, 1'b1);
    setp(PH_LIGHT_OFF);
    go(2);
    chk(lit, 1'b0);
  endtask

  task t_ign;
    bus(1'b1, OFS_CTRL, 32'h0F);
    setp(PH_PREIGN);
    go(2);
    chk(ign, 1'b1);
    for (k = 0; k < 80 && pdn !== 1'b1; k++) go(1);
    chk(k >= 15 && k <= 50, 1'b1);
    setp(PH_SAFETY1);
    @(posedge clk);
    ign_bad <= 1'b1;
    for (n = 0; n < 300; n++) begin
      st;
      if (q[STAT_IGN_FAULT]) break;
    end
    chk(q[31:16], ERR_IGN_RELAY);
    go(2);
    chk(ign, 1'b0);
    @(posedge clk);
    ph <= 8'h00;
    ign_bad <= 1'b0;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      end_sim;
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_refuse;
    t_config;
    t_gate;
    t_std;
    t_fan;
    t_ign;
    end_sim;
  end
endmodule

bind fan_seq fan_seq_asserts #(.CYC_PER_MS_P(CYC_PER_MS_P)) i_chk (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .phase_in(phase_in),
  .at_prepurge_in(at_prepurge_in), .fan_on_out(fan_on_out),
  .speed_setpoint_out(speed_setpoint_out), .light_on_out(light_on_out),
  .ignition_out(ignition_out), .preign_done_out(preign_done_out),
  .shutdown_out(shutdown_out));
